// [inc/ramp_pkg.sv]
/*
  Shared constants and types for the frequency ramp generator: register
  offsets, field positions, reset values and the sequencer state encoding.
  Assumes a 32-bit APB register bus and a 34-bit signed ramp numerator.
*/
package ramp_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STEP0 = 8'h08;
  localparam logic [7:0] ADDR_STEP1 = 8'h0C;
  localparam logic [7:0] ADDR_SEG0 = 8'h10;
  localparam logic [7:0] ADDR_SEG1 = 8'h14;
  localparam logic [7:0] ADDR_BURST = 8'h18;
  localparam logic [7:0] ADDR_THR_LO = 8'h1C;
  localparam logic [7:0] ADDR_THR_HI = 8'h20;
  localparam logic [7:0] ADDR_LIML_LO = 8'h24;
  localparam logic [7:0] ADDR_LIML_HI = 8'h28;
  localparam logic [7:0] ADDR_LIMH_LO = 8'h2C;
  localparam logic [7:0] ADDR_LIMH_HI = 8'h30;
  localparam logic [7:0] ADDR_INIT = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_NUM = 8'h3C;
  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_HALVE = 2;
  localparam int CTRL_RECAL = 3;
  localparam int CTRL_REPSRC = 4;
  localparam int CTRL_TRIGA = 8;
  localparam int CTRL_TRIGB = 12;
  localparam int CMD_START = 0;
  // Segment configuration fields.
  localparam int SEG_SUCC = 16;
  localparam int SEG_ADV = 17;
  localparam int SEG_RESTORE = 19;
  // Advance and repeat-count source codes.
  localparam logic [1:0] SRC_TIMEOUT = 2'h0;
  localparam logic [1:0] SRC_TRIG_A = 2'h1;
  localparam logic [1:0] SRC_TRIG_B = 2'h2;
  // Trigger source codes.
  localparam logic [3:0] TRG_CLK_RISE = 4'h1;
  localparam logic [3:0] TRG_DIR_RISE = 4'h2;
  localparam logic [3:0] TRG_ALWAYS = 4'h4;
  localparam logic [3:0] TRG_CLK_FALL = 4'h9;
  localparam logic [3:0] TRG_DIR_FALL = 4'hA;
  // Reset values.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [33:0] LIML_RST = 34'h200000000;
  localparam logic [33:0] LIMH_RST = 34'h1FFFFFFFF;
  localparam logic [33:0] THR_RST = 34'h000000000;
  localparam logic [31:0] INIT_RST = 32'h00000000;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } state_e;
endpackage

// [inc/trig_if.sv]
/*
  Carrier between the ramp core and its pin trigger unit.
  Assumes both ends run on the same register clock.
*/
`timescale 1ns/1ps
interface trig_if;
  logic [3:0] src_a;
  logic [3:0] src_b;
  logic trig_a;
  logic trig_b;
  logic clk_rise;
  logic dir_level;
  modport unit (input src_a, input src_b, output trig_a, output trig_b,
    output clk_rise, output dir_level);
  modport core (output src_a, output src_b, input trig_a, input trig_b,
    input clk_rise, input dir_level);
endinterface

// [core/ramp_trigger.sv]
/*
  Pin trigger unit: synchronises the sweep clock and direction pins and
  decodes the two trigger sources into single-cycle edge events, or a constant level for the always code.
  Assumes the pins are asynchronous to pclk and change slowly.
*/
`timescale 1ns/1ps
module ramp_trigger (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pins.
  input wire logic sweep_clock_pin,
  input wire logic sweep_direction_pin,
  // Core side.
  trig_if.unit tif
);
  typedef struct packed {
    logic [2:0] csync;
    logic [2:0] dsync;
    logic cst;
    logic dst;
    logic [1:0] trig;
    logic crise;
  } trig_s;

  trig_s s_q, s_d;
  logic [3:0] ev;
  logic [3:0] code;

  // Stage 0 feeds stage 1 only; stages 1 and 2 must agree before a change counts.
  always_comb begin
    s_d = s_q;
    ev = 4'h0;
    code = 4'h0;
    s_d.csync = {s_q.csync[1:0], sweep_clock_pin};
    s_d.dsync = {s_q.dsync[1:0], sweep_direction_pin};
    if (s_q.csync[1] == s_q.csync[2]) begin
      s_d.cst = s_q.csync[2];
    end
    if (s_q.dsync[1] == s_q.dsync[2]) begin
      s_d.dst = s_q.dsync[2];
    end
    ev[0] = s_d.cst & ~s_q.cst;
    ev[1] = ~s_d.cst & s_q.cst;
    ev[2] = s_d.dst & ~s_q.dst;
    ev[3] = ~s_d.dst & s_q.dst;
    s_d.crise = ev[0];
    // Both triggers decode the same code table; invalid codes never fire.
    for (int i = 0; i < 2; i++) begin
      code = (i == 0) ? tif.src_a : tif.src_b;
      unique case (code)
        ramp_pkg::TRG_CLK_RISE: s_d.trig[i] = ev[0];
        ramp_pkg::TRG_DIR_RISE: s_d.trig[i] = ev[2];
        ramp_pkg::TRG_ALWAYS: s_d.trig[i] = 1'b1;
        ramp_pkg::TRG_CLK_FALL: s_d.trig[i] = ev[1];
        ramp_pkg::TRG_DIR_FALL: s_d.trig[i] = ev[3];
        default: s_d.trig[i] = 1'b0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign tif.trig_a = s_q.trig[0];
  assign tif.trig_b = s_q.trig[1];
  assign tif.clk_rise = s_q.crise;
  assign tif.dir_level = s_q.dst;
endmodule

// [core/ramp_gen.sv]
/*
  Frequency ramp generator for a fractional-N synthesizer, with an APB
  register slave, a two-segment automatic sequencer and manual pin ramping.
  Assumes pd_tick is a one-cycle phase-detector pulse in the pclk domain and
  that the VCO calibrator answers each vco_cal_start with vco_cal_done.
*/
// Operation
// - Auto ramp only when enabled and not manual.
// - Writing calibration start launches the ramp.
// - Sweep clock is phase-detector clock, optionally halved.
// - Segment lasts its length plus calibration time.
// - Signed 30-bit step added each sweep clock.
// - Successor bit picks the following segment.
// - Advance source: timeout, trigger A, trigger B.
// - Trigger codes decode pin edges or always.
// - Restore bit returns numerator to start value.
// - Burst count ends a terminating pattern.
// - Burst count source: transition, trigger A, B.
// - Manual mode recalibrates every step when enabled.
// - Threshold movement forces a VCO recalibration.
// - Numerator is clamped between low and high limits.
// - Per-segment recalibration at each segment start.
`timescale 1ns/1ps
module ramp_gen #(
  parameter int NUM_W = 34
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Synthesizer side.
  input wire logic pd_tick,
  input wire logic vco_cal_done,
  output logic vco_cal_start,
  output logic [31:0] fraction_numerator,
  // Pins.
  input wire logic sweep_clock_pin,
  input wire logic sweep_direction_pin
);
  typedef struct packed {
    // Sequencer state.
    ramp_pkg::state_e st;
    // Configuration words.
    logic [15:0] ctrl;
    logic [29:0] step0;
    logic [29:0] step1;
    logic [19:0] cfg0;
    logic [19:0] cfg1;
    logic [12:0] burst;
    logic [NUM_W-1:0] thr;
    logic [NUM_W-1:0] liml;
    logic [NUM_W-1:0] limh;
    logic [31:0] init;
    // Running pattern.
    logic seg;
    logic [15:0] len;
    logic [NUM_W-1:0] num;
    logic [NUM_W-1:0] ref_n;
    logic [NUM_W-1:0] origin;
    logic [12:0] reps;
    // Halving, calibration, held triggers.
    logic half;
    logic cal_wait;
    logic cal_req;
    logic pend_a;
    logic pend_b;
    // Registered bus answer.
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_s;

  core_s s_q, s_d;
  trig_if tif ();

  // Bus phase decode.
  logic setup;
  logic wr;

  // Start command and mode bits.
  logic start;
  logic en;
  logic man;

  // Sweep clock and segment control.
  logic tick;
  logic busy;
  logic adv;
  logic do_step;

  // Current and next segment words.
  logic [19:0] cfg;
  logic [19:0] ncfg;
  logic [1:0] rsrc;

  // Step, clamped sum, threshold distance.
  logic [NUM_W-1:0] stp;
  logic [NUM_W-1:0] sum;
  logic [NUM_W-1:0] delta;

  // Trigger configuration handed to the pin unit.
  assign tif.src_a = s_q.ctrl[ramp_pkg::CTRL_TRIGA +: 4];
  assign tif.src_b = s_q.ctrl[ramp_pkg::CTRL_TRIGB +: 4];

  // Pin synchroniser and trigger decoder.
  ramp_trigger u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .sweep_clock_pin(sweep_clock_pin),
    .sweep_direction_pin(sweep_direction_pin),
    .tif(tif)
  );

  // Register access, sequencer and numerator arithmetic.
  always_comb begin
    // Pulses default low; all else holds.
    s_d = s_q;
    s_d.cal_req = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    start = 1'b0;
    adv = 1'b0;
    do_step = 1'b0;
    stp = '0;
    sum = '0;
    delta = '0;

    // Decoded bus, mode and segment views.
    setup = psel & ~penable;
    wr = psel & penable & pwrite & s_q.pready;
    en = s_q.ctrl[ramp_pkg::CTRL_ENABLE];
    man = s_q.ctrl[ramp_pkg::CTRL_MANUAL];
    rsrc = s_q.ctrl[ramp_pkg::CTRL_REPSRC +: 2];
    cfg = s_q.seg ? s_q.cfg1 : s_q.cfg0;
    ncfg = cfg[ramp_pkg::SEG_SUCC] ? s_q.cfg1 : s_q.cfg0;
    busy = s_q.cal_wait | s_q.cal_req;

    // Setup phase: prepare read data; the access phase follows with pready.
    if (setup) begin
      s_d.pready = 1'b1;
      // Unmapped and write-only words read 0.
      s_d.prdata = 32'h00000000;
      unique case (paddr)
        ramp_pkg::ADDR_CTRL: s_d.prdata = {16'h0000, s_q.ctrl};
        ramp_pkg::ADDR_CMD: s_d.prdata = 32'h00000000;
        ramp_pkg::ADDR_STEP0: s_d.prdata = {2'b00, s_q.step0};
        ramp_pkg::ADDR_STEP1: s_d.prdata = {2'b00, s_q.step1};
        ramp_pkg::ADDR_SEG0: s_d.prdata = {12'h000, s_q.cfg0};
        ramp_pkg::ADDR_SEG1: s_d.prdata = {12'h000, s_q.cfg1};
        ramp_pkg::ADDR_BURST: s_d.prdata = {19'h00000, s_q.burst};
        ramp_pkg::ADDR_THR_LO: s_d.prdata = s_q.thr[31:0];
        ramp_pkg::ADDR_THR_HI: s_d.prdata = {30'h00000000, s_q.thr[33:32]};
        ramp_pkg::ADDR_LIML_LO: s_d.prdata = s_q.liml[31:0];
        ramp_pkg::ADDR_LIML_HI: s_d.prdata = {30'h00000000, s_q.liml[33:32]};
        ramp_pkg::ADDR_LIMH_LO: s_d.prdata = s_q.limh[31:0];
        ramp_pkg::ADDR_LIMH_HI: s_d.prdata = {30'h00000000, s_q.limh[33:32]};
        ramp_pkg::ADDR_INIT: s_d.prdata = s_q.init;
        ramp_pkg::ADDR_STATUS: begin
          s_d.prdata = {12'h000, s_q.reps, s_q.cal_wait, s_q.seg, 2'b00, s_q.st};
        end
        ramp_pkg::ADDR_NUM: s_d.prdata = s_q.num[31:0];
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // Access phase: writes take effect at the edge that samples pready.
    if (wr) begin
      // Read-only and unmapped writes drop.
      unique case (paddr)
        ramp_pkg::ADDR_CTRL: s_d.ctrl = pwdata[15:0];
        ramp_pkg::ADDR_CMD: start = pwdata[ramp_pkg::CMD_START];
        ramp_pkg::ADDR_STEP0: s_d.step0 = pwdata[29:0];
        ramp_pkg::ADDR_STEP1: s_d.step1 = pwdata[29:0];
        ramp_pkg::ADDR_SEG0: s_d.cfg0 = pwdata[19:0];
        ramp_pkg::ADDR_SEG1: s_d.cfg1 = pwdata[19:0];
        ramp_pkg::ADDR_BURST: s_d.burst = pwdata[12:0];
        ramp_pkg::ADDR_THR_LO: s_d.thr[31:0] = pwdata;
        ramp_pkg::ADDR_THR_HI: s_d.thr[33:32] = pwdata[1:0];
        ramp_pkg::ADDR_LIML_LO: s_d.liml[31:0] = pwdata;
        ramp_pkg::ADDR_LIML_HI: s_d.liml[33:32] = pwdata[1:0];
        ramp_pkg::ADDR_LIMH_LO: s_d.limh[31:0] = pwdata;
        ramp_pkg::ADDR_LIMH_HI: s_d.limh[33:32] = pwdata[1:0];
        ramp_pkg::ADDR_INIT: s_d.init = pwdata;
        default: s_d.init = s_q.init;
      endcase
    end

    // Sweep clock: every phase-detector tick, or every second when halved.
    // Phase is cleared while halving is off.
    tick = pd_tick & (~s_q.ctrl[ramp_pkg::CTRL_HALVE] | s_q.half);
    if (pd_tick && s_q.ctrl[ramp_pkg::CTRL_HALVE]) begin
      s_d.half = ~s_q.half;
    end else if (!s_q.ctrl[ramp_pkg::CTRL_HALVE]) begin
      s_d.half = 1'b0;
    end

    // Calibration done clears the wait; a new request below wins.
    if (vco_cal_done) begin
      s_d.cal_wait = 1'b0;
    end

    // Trigger events are held until the sweep clock consumes them.
    // A timeout tick switches without a step.
    // Nothing moves while calibrating.
    if (s_q.st == ramp_pkg::ST_RUN && !busy && tick) begin
      if (cfg[ramp_pkg::SEG_ADV +: 2] == ramp_pkg::SRC_TIMEOUT) begin
        adv = (s_q.len == cfg[15:0]);
      end else if (cfg[ramp_pkg::SEG_ADV +: 2] == ramp_pkg::SRC_TRIG_A) begin
        adv = s_q.pend_a;
      end else if (cfg[ramp_pkg::SEG_ADV +: 2] == ramp_pkg::SRC_TRIG_B) begin
        adv = s_q.pend_b;
      end
      if (adv) begin
        s_d.seg = cfg[ramp_pkg::SEG_SUCC];
        s_d.len = 16'h0000;
        s_d.pend_a = 1'b0;
        s_d.pend_b = 1'b0;
        // Restore removes accumulated round-off.
        if (ncfg[ramp_pkg::SEG_RESTORE]) begin
          s_d.num = s_q.origin;
          s_d.ref_n = s_q.origin;
        end
        if (s_q.ctrl[ramp_pkg::CTRL_RECAL]) begin
          s_d.cal_req = 1'b1;
        end
        if (rsrc == ramp_pkg::SRC_TIMEOUT) begin
          s_d.reps = 13'(s_q.reps + 13'h0001);
        end
      end else begin
        do_step = 1'b1;
        stp = NUM_W'($signed(s_q.seg ? s_q.step1 : s_q.step0));
        s_d.len = 16'(s_q.len + 16'h0001);
      end
    end

    // A new event wins over the clear above.
    if (tif.trig_a) begin
      s_d.pend_a = 1'b1;
    end
    if (tif.trig_b) begin
      s_d.pend_b = 1'b1;
    end

    // Repeat counting on trigger events while the pattern runs.
    // Transitions count at the advance above.
    if (s_q.st == ramp_pkg::ST_RUN) begin
      if ((rsrc == ramp_pkg::SRC_TRIG_A && tif.trig_a) ||
          (rsrc == ramp_pkg::SRC_TRIG_B && tif.trig_b)) begin
        s_d.reps = 13'(s_q.reps + 13'h0001);
      end
      if (s_q.burst != 13'h0000 && s_d.reps >= s_q.burst) begin
        s_d.st = ramp_pkg::ST_HALT;
      end
    end

    // Manual pin ramping: direction picks the step; edges while calibrating are lost.
    // An edge is a one-cycle event, never queued.
    if (en && man && tif.clk_rise && !busy) begin
      do_step = 1'b1;
      stp = NUM_W'($signed(tif.dir_level ? s_q.step1 : s_q.step0));
      if (s_q.ctrl[ramp_pkg::CTRL_RECAL]) begin
        s_d.cal_req = 1'b1;
      end
    end

    // Step the numerator, clamp it and watch the recalibration threshold.
    if (do_step) begin
      sum = NUM_W'(s_q.num + stp);
      if ($signed(sum) > $signed(s_q.limh)) begin
        sum = s_q.limh;
      end else if ($signed(sum) < $signed(s_q.liml)) begin
        sum = s_q.liml;
      end
      s_d.num = sum;
      // Signed distance from ref_n, set at start, restore and the last threshold calibration.
      delta = NUM_W'(sum - s_q.ref_n);
      if (s_q.thr != '0 && ($signed(delta) >= $signed(s_q.thr) ||
          $signed(delta) <= -$signed(s_q.thr))) begin
        s_d.cal_req = 1'b1;
        s_d.ref_n = sum;
      end
    end

    // A start write while enabled loads the start value and calibrates; auto mode then runs.
    // In manual mode a start only loads and calibrates.
    if (start && en) begin
      s_d.num = NUM_W'(s_q.init);
      s_d.origin = NUM_W'(s_q.init);
      s_d.ref_n = NUM_W'(s_q.init);
      s_d.cal_req = 1'b1;
      if (!man) begin
        s_d.st = ramp_pkg::ST_RUN;
        s_d.seg = 1'b0;
        s_d.len = 16'h0000;
        s_d.reps = 13'h0000;
        s_d.pend_a = tif.trig_a;
        s_d.pend_b = tif.trig_b;
      end
    end

    // Leaving auto mode returns to idle.
    if (!en || man) begin
      s_d.st = ramp_pkg::ST_IDLE;
    end

    // Any request opens the calibration wait.
    if (s_d.cal_req) begin
      s_d.cal_wait = 1'b1;
    end
  end

  // State register with documented reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= ramp_pkg::ST_IDLE;
      s_q.ctrl <= ramp_pkg::CTRL_RST;
      s_q.thr <= ramp_pkg::THR_RST;
      s_q.liml <= ramp_pkg::LIML_RST;
      s_q.limh <= ramp_pkg::LIMH_RST;
      s_q.init <= ramp_pkg::INIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign vco_cal_start = s_q.cal_req;
  assign fraction_numerator = s_q.num[31:0];
endmodule

// [testbench/ramp_gen_monitor.sv]
/*
  Port checker for the ramp generator: bus answers and calibration handshakes.
  Assumes it is bound to ramp_gen and sees only that module's ports.
*/
`timescale 1ns/1ps
module ramp_gen_monitor #(
  parameter int NUM_W = 34
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Synthesizer side and pins.
  input wire logic pd_tick,
  input wire logic vco_cal_done,
  input wire logic vco_cal_start,
  input wire logic [31:0] fraction_numerator,
  input wire logic sweep_clock_pin,
  input wire logic sweep_direction_pin
);
  logic wr_acc;
  logic en_q;
  logic man_q;
  logic pend_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A write transfer that completes at this edge.
  assign wr_acc = psel && penable && pready && pwrite;
  // Follows the mode bits and whether a calibration is still open.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      man_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (wr_acc && paddr == ramp_pkg::ADDR_CTRL) begin
        en_q <= pwdata[ramp_pkg::CTRL_ENABLE];
        man_q <= pwdata[ramp_pkg::CTRL_MANUAL];
      end
      if (vco_cal_start) begin
        pend_q <= 1'b1;
      end else if (vco_cal_done) begin
        pend_q <= 1'b0;
      end
    end
  end
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("Access cycle came without ready.");
  a_ready_single: assert property (pready |=> !pready)
    else $error("Ready stood longer than one cycle.");
  a_err_unmapped: assert property (pready && paddr > 8'h3C |-> pslverr)
    else $error("Unmapped address gave no slave error.");
  a_err_mapped: assert property (pready && paddr <= 8'h3C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("Mapped address gave a slave error.");
  a_cmd_zero: assert property (
    pready && !pwrite && paddr == ramp_pkg::ADDR_CMD |-> prdata == 32'h00000000)
    else $error("Command register did not read zero.");
  a_start_cal: assert property (
    wr_acc && paddr == ramp_pkg::ADDR_CMD && pwdata[ramp_pkg::CMD_START] && en_q && !man_q
    |=> vco_cal_start)
    else $error("Start write gave no calibration request.");
  a_off_quiet: assert property (
    !en_q && !$past(en_q) && !$past(en_q, 2) |=> !vco_cal_start)
    else $error("Calibration requested while disabled.");
  a_cal_freeze: assert property (
    pend_q && !vco_cal_done |=> $stable(fraction_numerator))
    else $error("Numerator moved during calibration.");
  a_cal_single: assert property (vco_cal_start |=> !vco_cal_start)
    else $error("Calibration request longer than one cycle.");
endmodule
bind ramp_gen ramp_gen_monitor #(.NUM_W(NUM_W)) i_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pd_tick(pd_tick), .vco_cal_done(vco_cal_done), .vco_cal_start(vco_cal_start),
  .fraction_numerator(fraction_numerator), .sweep_clock_pin(sweep_clock_pin),
  .sweep_direction_pin(sweep_direction_pin)
);

// [testbench/test_frequency_ramp_generator.sv]
/*
  Self-checking bench for ramp_gen with a behavioural ramp model.
  Assumes the checker is bound by its own file and a 125 MHz pclk.
*/
`timescale 1ns/1ps
module test_frequency_ramp_generator;
  logic pclk, presetn, psel, penable, pwrite, pd_tick, vco_cal_done, serr;
  logic sweep_clock_pin, sweep_direction_pin, pready, pslverr, vco_cal_start;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, fraction_numerator, rv, lf;
  int fail_count, checks_done, seg, cnt, rep, halt, pend, alw, burst, ncal, k;
  int len[2], succ[2], rst[2], adv[2];
  int codes[$] = '{1, 2, 9, 10, 4};
  longint num, init, hi;
  longint stp[2];
  logic [7:0] ra[10] = '{ramp_pkg::ADDR_CTRL, ramp_pkg::ADDR_CMD, ramp_pkg::ADDR_LIML_LO,
    ramp_pkg::ADDR_LIML_HI, ramp_pkg::ADDR_LIMH_LO, ramp_pkg::ADDR_LIMH_HI,
    ramp_pkg::ADDR_THR_LO, ramp_pkg::ADDR_INIT, ramp_pkg::ADDR_STATUS, ramp_pkg::ADDR_NUM};
  logic [31:0] rx[10] = '{32'h0, 32'h0, 32'h0, 32'h2, 32'hFFFFFFFF, 32'h1, 32'h0, 32'h0,
    32'h1, 32'h0};
  logic [7:0] wa[3] = '{ramp_pkg::ADDR_STEP0, ramp_pkg::ADDR_SEG0, ramp_pkg::ADDR_BURST};
  logic [31:0] wm[3] = '{32'h3FFFFFFF, 32'h000FFFFF, 32'h00001FFF};
  ramp_gen i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_tick(pd_tick), .vco_cal_done(vco_cal_done), .vco_cal_start(vco_cal_start),
    .fraction_numerator(fraction_numerator), .sweep_clock_pin(sweep_clock_pin),
    .sweep_direction_pin(sweep_direction_pin)
  );
  // Free-running 8 ns clock.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Counts calibration request cycles.
  always @(posedge pclk) begin
    if (vco_cal_start === 1'b1) ncal++;
  end
  function logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One bus transfer; an idle edge follows so transfers never collide.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) chk("ready", 32'h0, 32'h1);
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", rv, e);
  endtask
  // Programs a ramp and mirrors it in the model.
  task cfg(input logic [31:0] c, s0, s1, g0, g1, b);
    logic [31:0] g[2];
    g = '{g0, g1};
    wr(ramp_pkg::ADDR_CTRL, c);
    wr(ramp_pkg::ADDR_STEP0, s0);
    wr(ramp_pkg::ADDR_STEP1, s1);
    wr(ramp_pkg::ADDR_SEG0, g0);
    wr(ramp_pkg::ADDR_SEG1, g1);
    wr(ramp_pkg::ADDR_BURST, b);
    stp[0] = longint'($signed(s0[29:0]));
    stp[1] = longint'($signed(s1[29:0]));
    burst = b;
    for (int i = 0; i < 2; i++) begin
      len[i] = g[i][15:0];
      succ[i] = g[i][16];
      adv[i] = g[i][18:17];
      rst[i] = g[i][19];
    end
  endtask
  task calw;
    int n;
    n = 0;
    while (ncal == 0 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    chk("calibration request", ncal, 32'h1);
    ncal = 0;
    repeat (2) @(posedge pclk);
  endtask
  task done_pulse;
    vco_cal_done <= 1'b1;
    @(posedge pclk);
    vco_cal_done <= 1'b0;
    @(posedge pclk);
  endtask
  task start;
    ncal = 0;
    wr(ramp_pkg::ADDR_CMD, 32'h00000001);
    num = init;
    seg = 0;
    cnt = 0;
    rep = 0;
    halt = 0;
    pend = 0;
    calw();
    chk("start numerator", fraction_numerator, num[31:0]);
    done_pulse();
  endtask
  // One phase-detector tick; the model moves only when upd is set.
  task tick(input int upd);
    pd_tick <= 1'b1;
    @(posedge pclk);
    pd_tick <= 1'b0;
    repeat (4) @(posedge pclk);
    if (alw) pend = 1;
    if (upd && !halt) begin
      if (adv[seg] == 0 ? cnt >= len[seg] : pend) begin
        pend = 0;
        seg = succ[seg];
        cnt = 0;
        rep++;
        if (rst[seg]) num = init;
        if (burst != 0 && rep == burst) halt = 1;
      end else begin
        num = num + stp[seg];
        if (num > hi) num = hi;
        cnt++;
      end
    end
    if (upd) chk("numerator", fraction_numerator, num[31:0]);
  endtask
  task pins(input logic v, input int c);
    if (c == 1 || c == 9) sweep_clock_pin <= v;
    else sweep_direction_pin <= v;
    repeat (8) @(posedge pclk);
    if ((v && c < 4) || (!v && c > 8)) pend = 1;
  endtask
  // Bounds a hung run.
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    finish_test();
  end
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, pd_tick, vco_cal_done} = 6'h00;
    {sweep_clock_pin, sweep_direction_pin, paddr, pwdata} = 42'h0;
    {fail_count, checks_done, alw, ncal} = 128'h0;
    lf = 32'h00000048;
    hi = 64'h00000001FFFFFFFF;
    init = 64'h0000000000100000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) rd(ra[i], rx[i]);
    for (int i = 0; i < 6; i++) begin
      lf = nxt(lf);
      wr(wa[i % 3], lf);
      rd(wa[i % 3], lf & wm[i % 3]);
    end
    wr(8'h40, lf);
    rd(8'h40, 32'h0);
    chk("slave error", {31'h0, serr}, 32'h1);
    wr(ramp_pkg::ADDR_INIT, init[31:0]);
    // Two segments with restore on the first only.
    cfg(32'h1, 32'h00001234, 32'h3FFFF000, 32'h00090003, 32'h00000002, 32'h0);
    start();
    repeat (14) tick(1);
    // Halved sweep clock: one step per tick pair.
    cfg(32'h5, 32'h00001234, 32'h3FFFF000, 32'h00090003, 32'h00000002, 32'h0);
    start();
    repeat (6) begin
      tick(0);
      tick(1);
    end
    // Two repeats of a self-looping segment, then halt.
    cfg(32'h1, 32'h00000100, 32'h0, 32'h00000001, 32'h00000001, 32'h2);
    start();
    repeat (6) tick(1);
    apb(1'b0, ramp_pkg::ADDR_STATUS, 32'h0);
    chk("state", {29'h0, rv[2:0]}, {29'h0, ramp_pkg::ST_HALT});
    // Every trigger code, alternating trigger A and B.
    foreach (codes[i]) begin
      k = codes[i];
      cfg(32'h1 | (k << (i % 2 ? 12 : 8)), 32'h100, 32'h0, 32'h00010064 | ((i % 2 + 1) << 17),
        32'h00080064, 32'h0);
      alw = (k == 4);
      start();
      tick(1);
      pins(1'b1, k);
      tick(1);
      pins(1'b0, k);
      tick(1);
      tick(1);
      alw = 0;
    end
    // Manual steps with a calibration after each; an edge during it is ignored.
    cfg(32'hB, 32'h100, 32'h3FFFFF00, 32'h0, 32'h0, 32'h0);
    start();
    sweep_clock_pin <= 1'b1;
    calw();
    num = num + stp[0];
    chk("manual step", fraction_numerator, num[31:0]);
    pins(1'b0, 1);
    pins(1'b1, 1);
    chk("ignored edge", fraction_numerator + ncal, num[31:0]);
    done_pulse();
    sweep_direction_pin <= 1'b1;
    pins(1'b0, 1);
    sweep_clock_pin <= 1'b1;
    calw();
    num = num + stp[1];
    chk("manual down step", fraction_numerator, num[31:0]);
    done_pulse();
    // Upper limit clamps the climb.
    hi = init + 64'h300;
    wr(ramp_pkg::ADDR_LIMH_LO, hi[31:0]);
    wr(ramp_pkg::ADDR_LIMH_HI, 32'h0);
    cfg(32'h1, 32'h100, 32'h0, 32'h00000010, 32'h00000010, 32'h0);
    start();
    repeat (5) tick(1);
    // Recalibration at segment start and on threshold movement.
    wr(ramp_pkg::ADDR_THR_LO, 32'h00000250);
    cfg(32'h9, 32'h100, 32'h0, 32'h2, 32'h2, 32'h0);
    start();
    repeat (2) tick(1);
    chk("early calibration", ncal, 32'h0);
    tick(1);
    calw();
    tick(0);
    chk("held numerator", fraction_numerator, num[31:0]);
    done_pulse();
    tick(1);
    calw();
    done_pulse();
    finish_test();
  end
endmodule
